// ### hw/dsa_device.sv
/*
 * Drive end: sense byte two, attention, selection, polling, index/sector
 * and reference clock generation.
 * Assumes link inputs are asynchronous and that firmware side inputs share
 * sys_clk; a command is reported on cmd_valid while param_pending is high.
 */
`timescale 1ns/1ps
module dsa_device #(
	parameter int REV_CYC = dsa_pkg::REV_CYC_DEF,
	parameter int SECT_CYC = dsa_pkg::SECT_CYC_DEF
) (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic srst, // synchronous reset
	dsa_link_if.dev lnk, // link to host
	input wire logic init_done, // initialize procedure finished, pulse
	input wire logic not_ready, // not-ready status level
	input wire logic reserved_here, // reserved to the port reading status
	input wire logic reserved_alt, // reserved to another port
	input wire logic forced_release, // release under way is forced
	input wire logic tbl_mod_b4, // table modification attribute bit 4
	input wire logic wr_disabled, // write control disables writing
	input wire logic in_prot_area, // heads in write protected area
	input wire logic vendor_attn, // vendor attention event, pulse
	input wire logic vendor_err, // vendor error level
	input wire logic fault_active, // other error still present
	input wire logic event_done, // completion or error event, pulse
	input wire logic attn_enable, // attention output enable
	input wire logic cmd_valid, // command decoded, pulse
	input wire dsa_pkg::dsa_cmd_t cmd_kind, // kind of that command
	input wire logic rd_bit, // read channel data
	output logic param_pending, // parameter request awaits a command
	output logic sense1_vendor, // sense byte one top bit
	output logic [7:0] sense2, // sense byte two
	output logic attn_cond, // attention condition
	output logic selected // device selected
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic strb_s1;
		logic strb_s2;
		logic strb_s3;
		logic dir_s1;
		logic dir_s2;
		logic line_s1;
		logic line_s2;
		logic preq_s1;
		logic preq_s2;
		logic preq_s3;
		logic sel;
		logic poll;
		logic sel_ack;
		logic pend;
		logic arm;
		logic pack;
		logic ack;
		logic [7:0] s2;
		logic nrdy;
		logic res_here;
		logic s1v;
		logic cond;
		logic attn_oe;
		logic [23:0] rev_cnt;
		logic [23:0] sect_cnt;
		logic idx;
		logic sect;
		logic [1:0] ref_cnt;
		logic ref_clk;
		logic rd;
	} dsa_dev_st_t;

	dsa_dev_st_t st_q;
	dsa_dev_st_t st_d;
	logic strb_rise;
	logic strb_fall;
	logic clr_attn;
	logic clr_fault;
	logic cmd_err;
	logic [7:0] s2_set;
	logic [7:0] s2_new;
	logic attn_set;
	logic idx_on;

	always_comb begin
		st_d = st_q;
		st_d.strb_s1 = lnk.strobe;
		st_d.strb_s2 = st_q.strb_s1;
		st_d.strb_s3 = st_q.strb_s2;
		st_d.dir_s1 = lnk.dir_out;
		st_d.dir_s2 = st_q.dir_s1;
		st_d.line_s1 = lnk.line;
		st_d.line_s2 = st_q.line_s1;
		st_d.preq_s1 = lnk.param_req;
		st_d.preq_s2 = st_q.preq_s1;
		st_d.preq_s3 = st_q.preq_s2;
		strb_rise = st_q.strb_s2 & ~st_q.strb_s3;
		strb_fall = ~st_q.strb_s2 & st_q.strb_s3;

		// ************************************************************
		// selection and polling
		// ************************************************************
		if (strb_rise) begin
			if (st_q.dir_s2) begin
				st_d.sel = st_q.line_s2;
			end else begin
				st_d.poll = 1'b1;
			end
		end
		if (strb_fall) begin
			st_d.poll = 1'b0;
		end
		// the acknowledge waits for the latched selection, one cycle after the edge
		st_d.sel_ack = st_q.strb_s2 & st_q.strb_s3 & st_q.sel;

		// ************************************************************
		// parameter request handshake
		// ************************************************************
		clr_attn = 1'b0;
		clr_fault = 1'b0;
		cmd_err = 1'b0;
		st_d.arm = 1'b0;
		if (st_q.preq_s2 & ~st_q.preq_s3) begin
			st_d.pend = 1'b1;
		end
		if (st_q.pend & cmd_valid) begin
			st_d.pend = 1'b0;
			st_d.arm = 1'b1;
			clr_attn = (cmd_kind == dsa_pkg::DSA_CMD_CLR_ATTN);
			clr_fault = (cmd_kind == dsa_pkg::DSA_CMD_CLR_FAULT);
			cmd_err = (cmd_kind == dsa_pkg::DSA_CMD_ERROR);
		end
		// acknowledge one cycle after attention settles for the command
		if (st_q.arm) begin
			st_d.pack = 1'b1;
		end else if (~st_q.preq_s2) begin
			st_d.pack = 1'b0;
		end
		st_d.ack = st_d.sel_ack | st_d.pack;

		// ************************************************************
		// sense bytes
		// ************************************************************
		st_d.nrdy = not_ready;
		st_d.res_here = reserved_here;
		s2_set = 8'h00;
		s2_set[dsa_pkg::S2_INIT] = init_done;
		s2_set[dsa_pkg::S2_RDY] = not_ready ^ st_q.nrdy;
		s2_set[dsa_pkg::S2_FORCED] = st_q.res_here & ~reserved_here & forced_release;
		s2_set[dsa_pkg::S2_TBL] = tbl_mod_b4;
		s2_set[dsa_pkg::S2_VEND] = vendor_attn;
		// a set arriving with a clear wins
		s2_new = (st_q.s2 & ~(clr_attn ? dsa_pkg::S2_STICKY_MASK : 8'h00)) | s2_set;
		s2_new = s2_new & dsa_pkg::S2_STICKY_MASK;
		s2_new[dsa_pkg::S2_RES_HERE] = reserved_here;
		s2_new[dsa_pkg::S2_RES_ALT] = reserved_alt;
		// either cause alone marks the position; value while seeking is unspecified
		s2_new[dsa_pkg::S2_WPROT] = wr_disabled | in_prot_area;
		st_d.s2 = s2_new;
		if (vendor_err) begin
			st_d.s1v = 1'b1;
		end else if (clr_fault) begin
			st_d.s1v = 1'b0;
		end

		// ************************************************************
		// attention
		// ************************************************************
		attn_set = (|(s2_new & ~st_q.s2 & dsa_pkg::S2_ATTN_MASK)) | event_done
			| (vendor_err & ~st_q.s1v) | cmd_err;
		if (attn_set) begin
			st_d.cond = 1'b1;
		end else if (clr_attn) begin
			st_d.cond = 1'b0;
		end else if (clr_fault & ~fault_active & ~vendor_err) begin
			st_d.cond = 1'b0;
		end
		st_d.attn_oe = st_d.cond & attn_enable;

		// ************************************************************
		// index, sector and reference clock
		// ************************************************************
		if (st_q.rev_cnt == 24'(REV_CYC - 1)) begin
			st_d.rev_cnt = 24'h000000;
		end else begin
			st_d.rev_cnt = st_q.rev_cnt + 24'h000001;
		end
		if (st_q.rev_cnt == 24'(REV_CYC - 1) || st_q.sect_cnt == 24'(SECT_CYC - 1)) begin
			st_d.sect_cnt = 24'h000000;
		end else begin
			st_d.sect_cnt = st_q.sect_cnt + 24'h000001;
		end
		idx_on = st_d.rev_cnt < 24'(dsa_pkg::PULSE_CYC);
		st_d.idx = idx_on & st_d.sel;
		st_d.sect = (st_d.sect_cnt < 24'(dsa_pkg::PULSE_CYC)) & ~idx_on & st_d.sel;
		if (st_q.ref_cnt == 2'(dsa_pkg::REF_HALF_CYC - 1)) begin
			st_d.ref_cnt = 2'h0;
			st_d.ref_clk = ~st_q.ref_clk;
		end else begin
			st_d.ref_cnt = st_q.ref_cnt + 2'h1;
		end
		st_d.rd = rd_bit;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign lnk.dev_line_o = st_q.cond;
	assign lnk.dev_line_oe = st_q.poll;
	assign lnk.bus_ack = st_q.ack;
	assign lnk.attn_oe = st_q.attn_oe;
	assign lnk.index = st_q.idx;
	assign lnk.sector = st_q.sect;
	assign lnk.ref_clk = st_q.ref_clk;
	assign lnk.read_data = st_q.rd;
	assign param_pending = st_q.pend;
	assign sense1_vendor = st_q.s1v;
	assign sense2 = st_q.s2;
	assign attn_cond = st_q.cond;
	assign selected = st_q.sel;
endmodule

// ### hw/dsa_pkg.sv
/*
 * Constants shared by both ends of the disk status/select/attention link.
 * Assumes one 40 MHz clock on both ends and a synchronous active high reset.
 */
// What this block does
// - sense one vendor error: clear-fault clears if gone
// - initial state bit sets, raises attention
// - ready transition bit on any not-ready change
// - reserved-here bit mirrors reservation to this port
// - forced release bit, cleared by clear-attention
// - reserved-alternate bit mirrors reservation elsewhere
// - table modified bit sets, raises attention
// - write protected bit follows protection state
// - vendor attention bit, cleared by clear-attention
// - strobe rise latches select, acknowledge answers
// - host samples acknowledge at strobe fall
// - strobe with no line asserted deselects
// - command error: attention before acknowledge
// - other events raise attention at once
// - clears drop attention before acknowledge
// - clear-fault keeps attention while error persists
// - poll: devices gate attention onto line
// - one index pulse per revolution, sectors
// - no sector pulse during index
// - host ignores index 500 ns after select
// - host write clock follows reference clock
// - host ignores read data while writing
package dsa_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_NS = 25;
	localparam int STROBE_NS = 500;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int IDX_VALID_NS = 500;
	localparam int IDX_VALID_CYC = (IDX_VALID_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_NS = 500;
	localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int REV_CYC_DEF = 666667;
	localparam int SECT_CYC_DEF = 20834;
	localparam int REF_HALF_CYC = 2;

	// ************************************************************
	// sense byte two positions and command kinds
	// ************************************************************
	localparam int S2_INIT = 0;
	localparam int S2_RDY = 1;
	localparam int S2_RES_HERE = 2;
	localparam int S2_FORCED = 3;
	localparam int S2_RES_ALT = 4;
	localparam int S2_TBL = 5;
	localparam int S2_WPROT = 6;
	localparam int S2_VEND = 7;
	localparam logic [7:0] S2_RESET = 8'h00;
	localparam logic [7:0] S2_ATTN_MASK = 8'ha3;
	localparam logic [7:0] S2_STICKY_MASK = 8'hab;

	typedef enum logic [1:0] {
		DSA_CMD_OTHER,
		DSA_CMD_CLR_ATTN,
		DSA_CMD_CLR_FAULT,
		DSA_CMD_ERROR
	} dsa_cmd_t;

	// ************************************************************
	// host registers (apb byte offsets and fields)
	// ************************************************************
	localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
	localparam logic [7:0] HOST_STAT_OFS = 8'h04;
	localparam int CTRL_SEL = 0;
	localparam int CTRL_DESEL = 1;
	localparam int CTRL_POLL = 2;
	localparam int CTRL_PARAM = 3;
	localparam int CTRL_WGATE = 4;
	localparam int ST_BUSY = 0;
	localparam int ST_PRESENT = 1;
	localparam int ST_POLL_ATTN = 2;
	localparam int ST_ATTN = 3;
	localparam int ST_IDX = 4;
	localparam int ST_SECT = 5;
	localparam int ST_PDONE = 6;
	localparam int ST_RDATA = 7;
endpackage

// ### hw/dsa_link_if.sv
/*
 * Link between one drive and its host controller.
 * Assumes the bench joins both ends; open-collector lines resolve here.
 */
`timescale 1ns/1ps
interface dsa_link_if;
	logic strobe;
	logic dir_out;
	logic host_line_o;
	logic host_line_oe;
	logic dev_line_o;
	logic dev_line_oe;
	logic param_req;
	logic bus_ack;
	logic attn_oe;
	logic attn_n;
	logic line;
	logic index;
	logic sector;
	logic ref_clk;
	logic write_clk;
	logic write_gate;
	logic read_data;

	// attention pulls low when the device enables it; on the line the host's driver wins, then the device's, else low
	assign attn_n = ~attn_oe;
	assign line = host_line_oe ? host_line_o : (dev_line_oe ? dev_line_o : 1'b0);

	modport dev (input strobe, dir_out, line, param_req, write_clk, write_gate,
		output dev_line_o, dev_line_oe, bus_ack, attn_oe, index, sector, ref_clk,
		read_data);
	modport host (input bus_ack, attn_n, line, index, sector, ref_clk, read_data,
		output strobe, dir_out, host_line_o, host_line_oe, param_req, write_clk,
		write_gate);
endinterface

// ### hw/dsa_host.sv
/*
 * Host controller end: apb registers, select/deselect/poll strobes,
 * parameter request, index validity and write clock.
 * Assumes link inputs are asynchronous; apb shares sys_clk.
 */
`timescale 1ns/1ps
module dsa_host (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic srst, // synchronous reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	dsa_link_if.host lnk // link to drive
);
	typedef enum logic [1:0] {H_IDLE, H_STRB, H_PARAM} dsa_hstate_t;

	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		dsa_hstate_t fsm;
		logic [4:0] cnt;
		logic is_poll;
		logic strobe;
		logic dir;
		logic line_oe;
		logic preq;
		logic present;
		logic poll_attn;
		logic pdone;
		logic sel_seen;
		logic [4:0] vcnt;
		logic wclk;
		logic wgate;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dsa_host_st_t;

	dsa_host_st_t st_q;
	dsa_host_st_t st_d;
	logic ack_s;
	logic attn_s;
	logic line_s;
	logic valid;
	logic [31:0] stat;
	logic wr_ctrl;

	always_comb begin
		st_d = st_q;
		// synchronised pins: read data, ack, attention, line, index, sector, reference clock
		st_d.s1 = {lnk.read_data, lnk.bus_ack, ~lnk.attn_n, lnk.line, lnk.index, lnk.sector,
			lnk.ref_clk};
		st_d.s2 = st_q.s1;
		ack_s = st_q.s2[5];
		attn_s = st_q.s2[4];
		line_s = st_q.s2[3];
		valid = st_q.sel_seen & (st_q.vcnt == 5'(dsa_pkg::IDX_VALID_CYC));

		// ************************************************************
		// apb slave, answers on the second access cycle
		// ************************************************************
		stat = 32'h00000000;
		stat[dsa_pkg::ST_BUSY] = (st_q.fsm != H_IDLE);
		stat[dsa_pkg::ST_PRESENT] = st_q.present;
		stat[dsa_pkg::ST_POLL_ATTN] = st_q.poll_attn;
		stat[dsa_pkg::ST_ATTN] = attn_s;
		stat[dsa_pkg::ST_IDX] = st_q.s2[2] & valid;
		stat[dsa_pkg::ST_SECT] = st_q.s2[1] & valid;
		stat[dsa_pkg::ST_PDONE] = st_q.pdone;
		stat[dsa_pkg::ST_RDATA] = st_q.s2[6] & ~st_q.wgate;
		wr_ctrl = 1'b0;
		st_d.pready = 1'b0;
		if (psel & penable & ~st_q.pready) begin
			st_d.pready = 1'b1;
			st_d.pslverr = 1'b0;
			st_d.prdata = 32'h00000000;
			if (paddr == dsa_pkg::HOST_CTRL_OFS) begin
				st_d.prdata[dsa_pkg::CTRL_WGATE] = st_q.wgate;
			end else if (paddr == dsa_pkg::HOST_STAT_OFS) begin
				st_d.prdata = stat;
			end else begin
				st_d.pslverr = 1'b1;
			end
		end
		if (psel & penable & st_q.pready & pwrite & (paddr == dsa_pkg::HOST_CTRL_OFS)) begin
			wr_ctrl = 1'b1;
			st_d.wgate = pwdata[dsa_pkg::CTRL_WGATE];
		end

		// ************************************************************
		// strobe sequencer; orders while busy are dropped
		// ************************************************************
		case (st_q.fsm)
			H_IDLE: begin
				if (wr_ctrl & (pwdata[dsa_pkg::CTRL_SEL] | pwdata[dsa_pkg::CTRL_DESEL]
					| pwdata[dsa_pkg::CTRL_POLL])) begin
					st_d.fsm = H_STRB;
					st_d.cnt = 5'h00;
					st_d.is_poll = pwdata[dsa_pkg::CTRL_POLL];
					st_d.strobe = 1'b1;
					st_d.dir = ~pwdata[dsa_pkg::CTRL_POLL];
					// deselect drives no line at all
					st_d.line_oe = pwdata[dsa_pkg::CTRL_SEL] & ~pwdata[dsa_pkg::CTRL_POLL];
					// a poll leaves the selection, and so index validity, untouched
					st_d.sel_seen = st_q.sel_seen & pwdata[dsa_pkg::CTRL_POLL];
				end else if (wr_ctrl & pwdata[dsa_pkg::CTRL_PARAM]) begin
					st_d.fsm = H_PARAM;
					st_d.preq = 1'b1;
					st_d.pdone = 1'b0;
				end
			end
			H_STRB: begin
				st_d.cnt = st_q.cnt + 5'h01;
				if (st_q.cnt == 5'(dsa_pkg::STROBE_CYC - 1)) begin
					st_d.fsm = H_IDLE;
					st_d.strobe = 1'b0;
					st_d.line_oe = 1'b0;
					st_d.dir = 1'b1;
					if (st_q.is_poll) begin
						st_d.poll_attn = line_s;
					end else begin
						// no acknowledge by the strobe's end means no device
						st_d.present = ack_s;
						st_d.sel_seen = ack_s;
						st_d.vcnt = 5'h00;
					end
				end
			end
			H_PARAM: begin
				if (ack_s) begin
					st_d.fsm = H_IDLE;
					st_d.preq = 1'b0;
					st_d.pdone = 1'b1;
				end
			end
			default: begin
				st_d.fsm = H_IDLE;
			end
		endcase
		// validity counts from the strobe fall that ends the selecting cycle
		if (st_q.sel_seen & (st_q.vcnt != 5'(dsa_pkg::IDX_VALID_CYC))) begin
			st_d.vcnt = st_q.vcnt + 5'h01;
		end
		// fixed latency from reference clock keeps a constant phase
		st_d.wclk = st_q.s2[0];
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= '0;
			st_q.dir <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign lnk.strobe = st_q.strobe;
	assign lnk.dir_out = st_q.dir;
	assign lnk.host_line_o = 1'b1;
	assign lnk.host_line_oe = st_q.line_oe;
	assign lnk.param_req = st_q.preq;
	assign lnk.write_clk = st_q.wclk;
	assign lnk.write_gate = st_q.wgate;
endmodule

// ### dv/dsa_properties.sv
/*
 * Concurrent checks on the link between host and drive ends.
 * Assumes the bench feeds it the link signals by name, one clock domain.
 */
`timescale 1ns/1ps
module dsa_properties (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic srst, // synchronous reset
	input wire logic strobe, // select/attention strobe
	input wire logic dir_out, // bus direction out
	input wire logic line, // resolved dedicated line
	input wire logic dev_line_oe, // device drives the line
	input wire logic bus_ack, // bus acknowledge
	input wire logic param_req, // parameter request
	input wire logic index, // index pulse
	input wire logic sector, // sector pulse
	input wire logic ref_clk, // reference clock
	input wire logic write_clk, // host write clock
	input wire logic write_gate // write gate
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	// ************
	// sequences
	// ************
	sequence s_sel;
		$rose(strobe) && dir_out && line;
	endsequence
	sequence s_desel;
		$rose(strobe) && dir_out && !line;
	endsequence
	sequence s_poll;
		$rose(strobe) && !dir_out;
	endsequence

	// ************
	// properties
	// ************
	property p_sel_ack;
		s_sel |-> ##[1:8] bus_ack;
	endproperty
	a_sel_ack: assert property (p_sel_ack) else $error("no ack after select");
	property p_ack_cause;
		$rose(bus_ack) |-> strobe || param_req;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_strobe_width;
		$rose(strobe) |-> strobe[*8];
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("strobe too short");
	property p_desel_quiet;
		s_desel |-> ##6 (!index && !sector)[*8];
	endproperty
	a_desel_quiet: assert property (p_desel_quiet) else $error("pulses after deselect");
	property p_poll_gate;
		s_poll |-> ##[1:4] dev_line_oe;
	endproperty
	a_poll_gate: assert property (p_poll_gate) else $error("poll not answered");
	property p_poll_release;
		$fell(strobe) |-> ##[0:4] !dev_line_oe;
	endproperty
	a_poll_release: assert property (p_poll_release) else $error("line held");
	property p_no_sect_at_idx;
		index |-> !sector;
	endproperty
	a_no_sect_at_idx: assert property (p_no_sect_at_idx) else $error("sector at index");
	property p_ref_clk;
		$rose(ref_clk) |=> ref_clk ##1 !ref_clk ##1 !ref_clk ##1 ref_clk;
	endproperty
	a_ref_clk: assert property (p_ref_clk) else $error("reference clock period");
	property p_wclk;
		$rose(write_clk) && write_gate ##4 write_gate |-> $rose(write_clk);
	endproperty
	a_wclk: assert property (p_wclk) else $error("write clock phase drift");
endmodule

// ### dv/disk_status_select_attention_tb.sv
/*
 * Self-checking bench: host end driven over apb, drive end by firmware inputs.
 * Assumes a shortened revolution so several index periods fit the run.
 */
`timescale 1ns/1ps
module disk_status_select_attention_tb;
	localparam int REV = 200;
	localparam int SECT = 50;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er;
	logic init_done = 1'b0, not_ready = 1'b0, res_here = 1'b0, res_alt = 1'b0, forced = 1'b0;
	logic tbl = 1'b0, wr_dis = 1'b0, prot = 1'b0, v_attn = 1'b0, v_err = 1'b0, fault = 1'b0;
	logic ev_done = 1'b0, attn_en = 1'b1, cmd_valid = 1'b0, rd_bit = 1'b0;
	dsa_pkg::dsa_cmd_t cmd_kind = dsa_pkg::DSA_CMD_OTHER;
	logic param_pending, sense1_vendor, attn_cond, selected, idx_q = 1'b0, sec_q = 1'b0;
	logic [7:0] sense2;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_idx = 0;
	int n_sec = 0;
	int n_try = 0;
	typedef struct packed {logic [3:0] kind; logic [3:0] bit_no; logic attn;} dsa_row_t;
	// event kind, sense byte two position (f = none), attention expected
	dsa_row_t rows [10] = '{'{4'h0, 4'h0, 1'b1}, '{4'h1, 4'h1, 1'b1}, '{4'h2, 4'h2, 1'b0},
		'{4'h3, 4'h3, 1'b0}, '{4'h4, 4'h4, 1'b0}, '{4'h5, 4'h5, 1'b1}, '{4'h6, 4'h6, 1'b0},
		'{4'h7, 4'h6, 1'b0}, '{4'h8, 4'h7, 1'b1}, '{4'h9, 4'hf, 1'b1}};

	dsa_link_if lnk();
	dsa_device #(.REV_CYC(REV), .SECT_CYC(SECT)) dsa_device_inst (.sys_clk(sys_clk),
		.srst(srst), .lnk(lnk), .init_done(init_done), .not_ready(not_ready),
		.reserved_here(res_here), .reserved_alt(res_alt), .forced_release(forced),
		.tbl_mod_b4(tbl), .wr_disabled(wr_dis), .in_prot_area(prot), .vendor_attn(v_attn),
		.vendor_err(v_err), .fault_active(fault), .event_done(ev_done),
		.attn_enable(attn_en), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .rd_bit(rd_bit),
		.param_pending(param_pending), .sense1_vendor(sense1_vendor), .sense2(sense2),
		.attn_cond(attn_cond), .selected(selected));
	dsa_host dsa_host_inst (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(lnk));
	dsa_properties dsa_properties_inst (.sys_clk(sys_clk), .srst(srst), .strobe(lnk.strobe),
		.dir_out(lnk.dir_out), .line(lnk.line), .dev_line_oe(lnk.dev_line_oe),
		.bus_ack(lnk.bus_ack), .param_req(lnk.param_req), .index(lnk.index),
		.sector(lnk.sector), .ref_clk(lnk.ref_clk), .write_clk(lnk.write_clk),
		.write_gate(lnk.write_gate));

	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		idx_q <= lnk.index;
		sec_q <= lnk.sector;
		if (lnk.index && !idx_q) n_idx++;
		if (lnk.sector && !sec_q) n_sec++;
	end

	// ************
	// tasks
	// ************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) n_mismatch++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic stat();
		apb(1'b0, dsa_pkg::HOST_STAT_OFS, 32'h0);
	endtask
	// busy may rise a little after the write, hence the short pause before polling
	task automatic ctrl(input logic [31:0] v);
		int n;
		n = 0;
		apb(1'b1, dsa_pkg::HOST_CTRL_OFS, v);
		repeat (2) @(posedge sys_clk);
		do begin
			stat();
			n++;
		end while (rd[dsa_pkg::ST_BUSY] !== 1'b0 && n < 100);
		if (rd[dsa_pkg::ST_BUSY] !== 1'b0) n_mismatch++;
	endtask
	task automatic do_cmd(input dsa_pkg::dsa_cmd_t k, input logic exp_attn_n);
		int n;
		n = 0;
		apb(1'b1, dsa_pkg::HOST_CTRL_OFS, 32'h8);
		while (param_pending !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		while (lnk.bus_ack !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		if (lnk.bus_ack !== 1'b1) n_mismatch++;
		chk("attn_n at ack", {31'h0, exp_attn_n}, {31'h0, lnk.attn_n});
		repeat (10) @(posedge sys_clk);
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ************
	// sequence of tests
	// ************
	initial begin
		repeat (30000) @(posedge sys_clk);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		chk("sense2 reset", 32'h0, {24'h0, sense2});
		stat();
		chk("status reset", 32'h0, rd & 32'h77);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		ctrl(32'h1);
		chk("selected", 32'h1, {31'h0, selected});
		chk("present", 32'h1, {31'h0, rd[dsa_pkg::ST_PRESENT]});
		chk("index early", 32'h0, {31'h0, rd[dsa_pkg::ST_IDX]});
		n_try = 0;
		do begin
			stat();
			n_try++;
		end while (rd[dsa_pkg::ST_IDX] !== 1'b1 && n_try < 60);
		chk("index valid", 32'h1, {31'h0, rd[dsa_pkg::ST_IDX]});
		#1;
		n_idx = 0;
		n_sec = 0;
		repeat (2 * REV) @(posedge sys_clk);
		#1;
		chk("index count", 32'd2, n_idx);
		chk("sector count", 2 * (REV / SECT - 1), n_sec);
		foreach (rows[i]) begin
			@(posedge sys_clk);
			case (rows[i].kind)
				4'h0: init_done <= 1'b1;
				4'h1: not_ready <= ~not_ready;
				4'h2: res_here <= 1'b1;
				4'h3: forced <= 1'b1;
				4'h4: res_alt <= 1'b1;
				4'h5: tbl <= 1'b1;
				4'h6: wr_dis <= 1'b1;
				4'h7: prot <= 1'b1;
				4'h8: v_attn <= 1'b1;
				default: ev_done <= 1'b1;
			endcase
			if (rows[i].kind == 4'h3) res_here <= 1'b1;
			@(posedge sys_clk);
			init_done <= 1'b0;
			tbl <= 1'b0;
			v_attn <= 1'b0;
			ev_done <= 1'b0;
			if (rows[i].kind == 4'h3) res_here <= 1'b0;
			repeat (4) @(posedge sys_clk);
			chk("sense2", {24'h0, 8'h01 << rows[i].bit_no}, {24'h0, sense2});
			chk("attn_n", {31'h0, ~rows[i].attn}, {31'h0, lnk.attn_n});
			chk("attn_cond", {31'h0, rows[i].attn}, {31'h0, attn_cond});
			res_here <= 1'b0;
			res_alt <= 1'b0;
			wr_dis <= 1'b0;
			prot <= 1'b0;
			forced <= 1'b0;
			do_cmd(dsa_pkg::DSA_CMD_CLR_ATTN, 1'b1);
			chk("sense2 cleared", 32'h0, {24'h0, sense2});
		end
		do_cmd(dsa_pkg::DSA_CMD_ERROR, 1'b0);
		attn_en <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("attn masked", 32'h1, {31'h0, lnk.attn_n});
		attn_en <= 1'b1;
		ctrl(32'h4);
		chk("poll attn", 32'h1, {31'h0, rd[dsa_pkg::ST_POLL_ATTN]});
		do_cmd(dsa_pkg::DSA_CMD_CLR_ATTN, 1'b1);
		ctrl(32'h4);
		chk("poll quiet", 32'h0, {31'h0, rd[dsa_pkg::ST_POLL_ATTN]});
		v_err <= 1'b1;
		fault <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("vendor err", 32'h1, {31'h0, sense1_vendor});
		do_cmd(dsa_pkg::DSA_CMD_CLR_FAULT, 1'b0);
		v_err <= 1'b0;
		do_cmd(dsa_pkg::DSA_CMD_CLR_FAULT, 1'b0);
		chk("vendor err gone", 32'h0, {31'h0, sense1_vendor});
		fault <= 1'b0;
		do_cmd(dsa_pkg::DSA_CMD_CLR_FAULT, 1'b1);
		rd_bit <= 1'b1;
		apb(1'b1, dsa_pkg::HOST_CTRL_OFS, 32'h10);
		repeat (20) @(posedge sys_clk);
		stat();
		chk("rdata in write", 32'h0, {31'h0, rd[dsa_pkg::ST_RDATA]});
		apb(1'b1, dsa_pkg::HOST_CTRL_OFS, 32'h0);
		stat();
		chk("rdata", 32'h1, {31'h0, rd[dsa_pkg::ST_RDATA]});
		ctrl(32'h2);
		chk("deselected", 32'h0, {31'h0, selected});
		#1;
		n_idx = 0;
		repeat (REV + 10) @(posedge sys_clk);
		chk("index off", 32'h0, n_idx);
		wrap_up();
	end
endmodule
